// ==== rtl/pkg_power_coord.sv ====
package pkg_power_coord;

	typedef enum logic [2:0]
	{
		CORE_C0 = 3'b000,
		CORE_C1_HALT = 3'b001,
		CORE_C1_WAIT = 3'b010,
		CORE_C2 = 3'b011,
		CORE_C3 = 3'b100
	} core_state_e;

	typedef enum logic [1:0]
	{
		PKG_NORMAL = 2'b00,
		PKG_STOP_GRANT = 2'b01,
		PKG_DEEP_SLEEP = 2'b10
	} pkg_state_e;

	// one request from a core: kind and hint
	typedef struct packed
	{
		logic wait_req;
		logic [1:0] wait_hint;
		logic level_req;
		logic level3;
		logic halt_req;
		logic wake;
	} core_req_s;

	localparam logic [1:0] HINT_C1 = 2'h0;
	localparam logic [1:0] HINT_C2 = 2'h1;
	localparam logic [1:0] HINT_C3 = 2'h2;
	localparam logic [1:0] LVL2_HINT_RESET = 2'h1;
	localparam logic [1:0] LVL3_HINT_RESET = 2'h2;
	localparam int CLOCK_NS = 50;
	localparam int GRANT_BUS_CLOCKS = 20;
	localparam int GRANT_DELAY = 4;
	localparam logic [4:0] GRANT_CYCLES = 5'(GRANT_DELAY);

endpackage : pkg_power_coord

// ==== rtl/core_package_power_state_coord.sv ====
// Summary of operation
// - each core enters C1 halt, C1 wait, C2 or C3 independently.
// - both cores in same low state issue level-2 or level-3 read to hub.
// - requests come by wait instruction hints or by level register reads.
// - level reads become internal wait requests, never bus I/O reads.
// - level reads need no armed monitor address.
// - hint for each level read comes from misc enable register setting.
// - break event during stop-clock request asserts pending-break output.
// - Normal if any core C0/C1; Deep Sleep only both C3; else Stop-Grant.
// - each core reaches Stop-Grant within 20 bus clocks of its acknowledge.
// - any latched interrupt, even masked, or monitor event drives pending-break.
`timescale 1ns/1ps

module core_package_power_state_coord
	import pkg_power_coord::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire core_req_s req0,
	input wire core_req_s req1,
	input wire logic [1:0] lvl2_hint_cfg,
	input wire logic [1:0] lvl3_hint_cfg,
	input wire logic hint_cfg_write,
	input wire logic stop_clock_request_n,
	input wire logic [1:0] break_event,
	input wire logic [1:0] ack_response,
	output core_state_e core0_state,
	output core_state_e core1_state,
	output pkg_state_e pkg_state,
	output logic level_read_request,
	output logic level_read_is_c3,
	output logic pending_break_event_n,
	output logic [1:0] stop_granted
);

	logic [1:0] misc_lvl2_hint;
	logic [1:0] misc_lvl3_hint;
	logic [1:0] pending;
	logic [4:0] grant_cnt0;
	logic [4:0] grant_cnt1;
	logic both_low_prev;
	core_state_e next_core0;
	core_state_e next_core1;
	pkg_state_e next_pkg;

	wire stop_active = !stop_clock_request_n;

	// level read maps to a wait hint; no monitor arming is consulted
	function automatic core_state_e hint_to_state(input logic [1:0] hint);
		unique case (hint)
			HINT_C1: return CORE_C1_WAIT;
			HINT_C2: return CORE_C2;
			default: return CORE_C3;
		endcase
	endfunction : hint_to_state

	function automatic core_state_e step(input core_state_e cur, input core_req_s r,
		input logic [1:0] h2, input logic [1:0] h3);
		if (r.wake)
			return CORE_C0;
		else if (cur != CORE_C0)
			return cur;
		else if (r.level_req)
			return hint_to_state(r.level3 ? h3 : h2);
		else if (r.wait_req)
			return hint_to_state(r.wait_hint);
		else if (r.halt_req)
			return CORE_C1_HALT;
		else
			return CORE_C0;
	endfunction : step

	function automatic logic is_deep(input core_state_e s);
		return (s == CORE_C2) || (s == CORE_C3);
	endfunction : is_deep

	// cores stepped separately, no cross term
	assign next_core0 = step(core0_state, req0, misc_lvl2_hint, misc_lvl3_hint);
	assign next_core1 = step(core1_state, req1, misc_lvl2_hint, misc_lvl3_hint);

	// computed from next states so a change is seen at once
	assign next_pkg = (next_core0 == CORE_C3 && next_core1 == CORE_C3) ? PKG_DEEP_SLEEP :
		(is_deep(next_core0) && is_deep(next_core1)) ? PKG_STOP_GRANT : PKG_NORMAL;

	wire both_low = (next_pkg != PKG_NORMAL);
	wire common = both_low && (next_core0 == next_core1);

	// counters park at zero outside a stop request, so a stale ack cannot grant later
	wire [4:0] next_grant_cnt0 = !stop_active ? 5'h00 :
		ack_response[0] ? GRANT_CYCLES :
		(grant_cnt0 != 5'h00) ? grant_cnt0 - 5'h01 : 5'h00;
	wire [4:0] next_grant_cnt1 = !stop_active ? 5'h00 :
		ack_response[1] ? GRANT_CYCLES :
		(grant_cnt1 != 5'h00) ? grant_cnt1 - 5'h01 : 5'h00;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			core0_state <= CORE_C0;
			core1_state <= CORE_C0;
			pkg_state <= PKG_NORMAL;
		end
		else
		begin
			core0_state <= next_core0;
			core1_state <= next_core1;
			pkg_state <= next_pkg;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			misc_lvl2_hint <= LVL2_HINT_RESET;
			misc_lvl3_hint <= LVL3_HINT_RESET;
		end
		else if (hint_cfg_write)
		begin
			misc_lvl2_hint <= lvl2_hint_cfg;
			misc_lvl3_hint <= lvl3_hint_cfg;
		end
	end

	// one-cycle hub read on entry to a common low state
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			both_low_prev <= 1'b0;
			level_read_request <= 1'b0;
			level_read_is_c3 <= 1'b0;
		end
		else
		begin
			both_low_prev <= common;
			level_read_request <= common && !both_low_prev;
			level_read_is_c3 <= next_core0 == CORE_C3;
		end
	end

	// break events latched per core, masked or not; cleared on wake
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pending <= 2'b00;
			pending_break_event_n <= 1'b1;
		end
		else
		begin
			pending[0] <= break_event[0] || (pending[0] && !req0.wake);
			pending[1] <= break_event[1] || (pending[1] && !req1.wake);
			pending_break_event_n <= !(stop_active && (|pending || |break_event));
		end
	end

	// grant counts from acknowledge response; early limit well within bound
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			grant_cnt0 <= 5'h00;
			grant_cnt1 <= 5'h00;
			stop_granted <= 2'b00;
		end
		else
		begin
			grant_cnt0 <= next_grant_cnt0;
			grant_cnt1 <= next_grant_cnt1;
			stop_granted[0] <= stop_active && (stop_granted[0] || grant_cnt0 == 5'h01);
			stop_granted[1] <= stop_active && (stop_granted[1] || grant_cnt1 == 5'h01);
		end
	end

	pkg_map_a: assert property (@(posedge clock) disable iff (!nrst)
		(core0_state == CORE_C3 && core1_state == CORE_C3) == (pkg_state == PKG_DEEP_SLEEP))
		else $error("deep sleep mismatch");

	pkg_normal_a: assert property (@(posedge clock) disable iff (!nrst)
		(!is_deep(core0_state) || !is_deep(core1_state)) |-> pkg_state == PKG_NORMAL)
		else $error("normal mismatch");

	grant_time_a: assert property (@(posedge clock) disable iff (!nrst)
		(stop_active && ack_response[0]) ##1 stop_active [*5] |-> stop_granted[0])
		else $error("core0 grant late");

	grant_time1_a: assert property (@(posedge clock) disable iff (!nrst)
		(stop_active && ack_response[1]) ##1 stop_active [*5] |-> stop_granted[1])
		else $error("core1 grant late");

	pbe_a: assert property (@(posedge clock) disable iff (!nrst)
		(stop_active && |break_event) ##1 stop_active |-> !pending_break_event_n)
		else $error("break not flagged");

	pbe_idle_a: assert property (@(posedge clock) disable iff (!nrst)
		$past(stop_clock_request_n) |-> pending_break_event_n)
		else $error("pbe without stop clock");

	hub_read_a: assert property (@(posedge clock) disable iff (!nrst)
		level_read_request |-> core0_state == core1_state && pkg_state != PKG_NORMAL)
		else $error("hub read without common state");

	level_c3_a: assert property (@(posedge clock) disable iff (!nrst)
		(level_read_request && level_read_is_c3) |-> core0_state == CORE_C3 && pkg_state == PKG_DEEP_SLEEP)
		else $error("level three read without deep sleep");

	indep_a: assert property (@(posedge clock) disable iff (!nrst)
		(core0_state == CORE_C0 && req0.halt_req && !req0.wake && !req0.level_req && !req0.wait_req)
		|=> core0_state == CORE_C1_HALT)
		else $error("core0 halt not independent");

	level_hint_a: assert property (@(posedge clock) disable iff (!nrst)
		(core1_state == CORE_C0 && req1.level_req && !req1.wake && !req1.level3 && misc_lvl2_hint == HINT_C2)
		|=> core1_state == CORE_C2)
		else $error("level hint ignored");

	wake_a: assert property (@(posedge clock) disable iff (!nrst)
		req0.wake |=> core0_state == CORE_C0 && pkg_state == PKG_NORMAL)
		else $error("wake not reflected");

endmodule : core_package_power_state_coord

// ==== verification/hub_model.sv ====
`timescale 1ns/1ps
module hub_model
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic stop_on,
	input wire logic pending_break_event_n,
	output logic stop_clock_request_n,
	output logic [1:0] ack_response,
	output logic wake_demand
);
	logic stop_seen;
	// both cores acknowledge together: one pulse per stop request
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
		begin
			stop_clock_request_n <= 1'b1;
			stop_seen <= 1'b0;
			ack_response <= 2'h0;
			wake_demand <= 1'b0;
		end
		else
		begin
			stop_clock_request_n <= !stop_on;
			stop_seen <= !stop_clock_request_n;
			ack_response <= {2{!stop_clock_request_n && !stop_seen}};
			wake_demand <= !pending_break_event_n && !stop_clock_request_n;
		end
endmodule : hub_model

// ==== verification/core_package_power_state_coord_tb.sv ====
`timescale 1ns/1ps
module core_package_power_state_coord_tb;
	import pkg_power_coord::*;
	typedef struct packed
	{
		logic [6:0] r0;
		logic [6:0] r1;
		core_state_e s0;
		core_state_e s1;
		pkg_state_e p;
		logic lr;
		logic c3;
	} row_s;
	logic clock = 0;
	logic nrst = 0;
	core_req_s req0 = '0;
	core_req_s req1 = '0;
	logic [1:0] h2 = 2'h1;
	logic hw = 0;
	logic stop_on = 0;
	logic [1:0] brk = 2'h0;
	logic stop_n, wake_demand, lr, c3, pbe_n;
	logic [1:0] ack, granted;
	core_state_e s0, s1;
	pkg_state_e p;
	int n_mismatch = 0;
	int check_count = 0;
	row_s rows [7];
	always #25 clock = ~clock;
	hub_model partner (.clock(clock), .nrst(nrst), .stop_on(stop_on), .pending_break_event_n(pbe_n),
		.stop_clock_request_n(stop_n), .ack_response(ack), .wake_demand(wake_demand));
	core_package_power_state_coord dut (.clock(clock), .nrst(nrst),
		.req0(core_req_s'(req0 | 7'(wake_demand))), .req1(core_req_s'(req1 | 7'(wake_demand))),
		.lvl2_hint_cfg(h2), .lvl3_hint_cfg(2'h2), .hint_cfg_write(hw), .stop_clock_request_n(stop_n),
		.break_event(brk), .ack_response(ack), .core0_state(s0), .core1_state(s1), .pkg_state(p),
		.level_read_request(lr), .level_read_is_c3(c3), .pending_break_event_n(pbe_n), .stop_granted(granted));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// wake both, then request, look half a cycle after the request is taken
	task automatic run(input row_s r);
		req0 <= 7'h01;
		req1 <= 7'h01;
		@(posedge clock);
		req0 <= r.r0;
		req1 <= r.r1;
		@(posedge clock);
		req0 <= '0;
		req1 <= '0;
		@(negedge clock);
		check(s0, r.s0, "core0");
		check(s1, r.s1, "core1");
		check(p, r.p, "package");
		check(lr, r.lr, "level read");
		if (r.lr)
			check(c3, r.c3, "level c3");
		@(posedge clock);
	endtask : run
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		rows[0] = '{7'h02, 7'h02, CORE_C1_HALT, CORE_C1_HALT, PKG_NORMAL, 1'b0, 1'b0};
		rows[1] = '{7'h40, 7'h50, CORE_C1_WAIT, CORE_C2, PKG_NORMAL, 1'b0, 1'b0};
		rows[2] = '{7'h50, 7'h50, CORE_C2, CORE_C2, PKG_STOP_GRANT, 1'b1, 1'b0};
		rows[3] = '{7'h50, 7'h60, CORE_C2, CORE_C3, PKG_STOP_GRANT, 1'b0, 1'b0};
		rows[4] = '{7'h00, 7'h60, CORE_C0, CORE_C3, PKG_NORMAL, 1'b0, 1'b0};
		rows[5] = '{7'h08, 7'h08, CORE_C2, CORE_C2, PKG_STOP_GRANT, 1'b1, 1'b0};
		rows[6] = '{7'h0C, 7'h60, CORE_C3, CORE_C3, PKG_DEEP_SLEEP, 1'b1, 1'b1};
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		check({s0, s1, p}, 8'h00, "reset states");
		check({pbe_n, granted}, 8'h04, "reset outputs");
		$display("reset test done");
		@(posedge clock);
		for (int i = 0; i < 7; i++)
			run(rows[i]);
		req0 <= 7'h50;
		@(posedge clock);
		req0 <= '0;
		@(negedge clock);
		check(s0, CORE_C3, "ignored request");
		$display("table test done");
		@(posedge clock);
		h2 <= 2'h2;
		hw <= 1'b1;
		@(posedge clock);
		hw <= 1'b0;
		run('{7'h08, 7'h08, CORE_C3, CORE_C3, PKG_DEEP_SLEEP, 1'b1, 1'b1});
		$display("hint test done");
		stop_on <= 1'b1;
		for (int i = 0; i < 10 && ack !== 2'h3; i++)
			@(negedge clock);
		check(granted, 2'h0, "grant before ack");
		for (int i = 0; i < 20 && granted !== 2'h3; i++)
			@(negedge clock);
		check(granted, 2'h3, "stop granted");
		@(posedge clock);
		brk <= 2'h1;
		@(posedge clock);
		brk <= 2'h0;
		@(negedge clock);
		check(pbe_n, 1'b0, "pending break");
		repeat (3) @(negedge clock);
		check({s0, p}, 8'h00, "woken by hub");
		check(s1, CORE_C0, "core1 woken by hub");
		$display("stop test done");
		@(posedge clock);
		nrst <= 1'b0;
		stop_on <= 1'b0;
		@(negedge clock);
		check({pbe_n, granted}, 8'h04, "mid reset outputs");
		@(posedge clock);
		nrst <= 1'b1;
		run(rows[2]);
		$display("mid reset test done");
		end_of_test();
	end
endmodule : core_package_power_state_coord_tb
